// >>> hw/dac_ctrl_pkg.sv
`default_nettype none
package dac_ctrl_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_LEVEL_SELECT      = 8'h04;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int POS_ENABLE    = 7;
   localparam int POS_LOW_POWER = 6;
   localparam int POS_PIN_OE    = 5;
   localparam int POS_PSS_LO    = 2;
   localparam int POS_NSS       = 0;

   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hED;
   localparam logic [7:0] LEVEL_WRITE_MASK   = 8'h1F;
   localparam logic [7:0] CONTROL_RESET      = 8'h00;
   localparam logic [4:0] LEVEL_RESET        = 5'h00;
   localparam logic [4:0] LEVEL_ALL_ONES     = 5'h1F;
   localparam logic [4:0] LEVEL_ALL_ZEROS    = 5'h00;

   // -----------------------------------------------------------------
   // Source selections
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      POS_SRC_SUPPLY   = 2'b00,
      POS_SRC_EXT_PIN  = 2'b01,
      POS_SRC_FIXED    = 2'b10,
      POS_SRC_RESERVED = 2'b11
   } positive_source_type;

   typedef enum logic [1:0] {
      MODE_OFF          = 2'b00,
      MODE_LADDER       = 2'b01,
      MODE_CLAMP_POS    = 2'b10,
      MODE_CLAMP_NEG    = 2'b11
   } ladder_mode_type;

   // Ladder switch controls handed to the analog macro.
   typedef struct packed {
      ladder_mode_type     mode;
      positive_source_type pos_source;
      logic                neg_ext_pin;
      logic                pos_connect;
      logic                neg_connect;
      logic [4:0]          ladder_level_code;
   } ladder_ctrl_type;

   // Reference-pin override controls handed to the pad.
   typedef struct packed {
      logic analog_route;
      logic digital_out_disable;
      logic digital_in_disable;
   } pin_ctrl_type;

endpackage
`default_nettype wire

// >>> hw/ratiometric_dac_control.sv
// Operation
// - Converter is enabled exactly while the enable bit is set.
// - Five-bit level code picks one of 32 ladder taps.
// - Pin output enable set routes converter voltage to reference pin.
// - While routed, pin digital driver and input detector are disabled.
// - While routed, a digital read of the pin returns zero.
// - Converter output also feeds comparator positive input and ADC channel.
// - Positive select: 00 supply, 01 external pin, 10 fixed buffer, 11 reserved.
// - Negative select: set picks external pin, clear picks ground.
// - Reset disables converter, removes pin routing, clears level code.
`timescale 1ns/10ps
`default_nettype none
module ratiometric_dac_control (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                cyc_i,
   input  wire logic                                stb_i,
   input  wire logic                                we_i,
   input  wire logic [7:0]                          adr_i,
   input  wire logic [3:0]                          sel_i,
   input  wire logic [31:0]                         dat_i,
   output logic      [31:0]                         dat_o,
   output logic                                     ack_o,
   output logic                                     err_o,
   input  wire logic                                pin_digital_in_i,
   output logic                                     pin_digital_read_o,
   output dac_ctrl_pkg::ladder_ctrl_type            ladder_ctrl_o,
   output dac_ctrl_pkg::pin_ctrl_type               pin_ctrl_o,
   output logic                                     comparator_ref_en_o,
   output logic                                     adc_ref_en_o
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [7:0] control;
   logic [4:0] level;
   logic       request;
   logic       hit_control;
   logic       hit_level;
   logic       mapped;

   assign request     = cyc_i && stb_i && !ack_o && !err_o;
   assign hit_control = adr_i == dac_ctrl_pkg::ADDR_REFERENCE_CONTROL;
   assign hit_level   = adr_i == dac_ctrl_pkg::ADDR_LEVEL_SELECT;
   assign mapped      = hit_control || hit_level;

   // Answer one cycle after the request is seen; single-cycle pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         ack_o <= request && mapped;
         err_o <= request && !mapped;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic write_strobe;
   assign write_strobe = request && we_i && sel_i[0];

   // Only byte lane 0 carries data, so other lanes are ignored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control <= dac_ctrl_pkg::CONTROL_RESET;
      end else if (write_strobe && hit_control) begin
         control <= dat_i[7:0] & dac_ctrl_pkg::CONTROL_WRITE_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level <= dac_ctrl_pkg::LEVEL_RESET;
      end else if (write_strobe && hit_level) begin
         level <= dat_i[4:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (request && !we_i && hit_control) begin
         dat_o <= {24'h00_0000, control};
      end else if (request && !we_i && hit_level) begin
         dat_o <= {27'h000_0000, level};
      end else begin
         dat_o <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Ladder control
   // ----------------------------------------------------------------
   logic enable;
   logic low_power;
   logic pin_oe;
   dac_ctrl_pkg::ladder_ctrl_type next_ladder;

   assign enable    = control[dac_ctrl_pkg::POS_ENABLE];
   assign low_power = control[dac_ctrl_pkg::POS_LOW_POWER];
   assign pin_oe    = control[dac_ctrl_pkg::POS_PIN_OE];

   always_comb begin
      next_ladder = '0;
      next_ladder.ladder_level_code = level;
      // The reserved positive code is passed as the supply, so the positive source is always a defined one.
      unique case (control[dac_ctrl_pkg::POS_PSS_LO +: 2])
         2'b00: next_ladder.pos_source = dac_ctrl_pkg::POS_SRC_SUPPLY;
         2'b01: next_ladder.pos_source = dac_ctrl_pkg::POS_SRC_EXT_PIN;
         2'b10: next_ladder.pos_source = dac_ctrl_pkg::POS_SRC_FIXED;
         default: next_ladder.pos_source = dac_ctrl_pkg::POS_SRC_SUPPLY;
      endcase
      next_ladder.neg_ext_pin = control[dac_ctrl_pkg::POS_NSS];
      if (enable) begin
         next_ladder.mode        = dac_ctrl_pkg::MODE_LADDER;
         next_ladder.pos_connect = 1'b1;
         next_ladder.neg_connect = 1'b1;
      end else if (low_power && level == dac_ctrl_pkg::LEVEL_ALL_ONES) begin
         next_ladder.mode        = dac_ctrl_pkg::MODE_CLAMP_POS;
         next_ladder.pos_connect = 1'b1;
      end else if (!low_power && level == dac_ctrl_pkg::LEVEL_ALL_ZEROS) begin
         next_ladder.mode        = dac_ctrl_pkg::MODE_CLAMP_NEG;
         next_ladder.neg_connect = 1'b1;
      end else begin
         // Low-power state still closes the positive end of the ladder; the negative end stays open.
         next_ladder.mode        = dac_ctrl_pkg::MODE_OFF;
         next_ladder.pos_connect = low_power;
         next_ladder.neg_connect = 1'b0;
      end
   end

   // Registered so switches move one cycle after the write completes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ladder_ctrl_o <= '0;
      end else begin
         ladder_ctrl_o <= next_ladder;
      end
   end

   // ----------------------------------------------------------------
   // Pin and internal consumers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_ctrl_o          <= '0;
         comparator_ref_en_o <= 1'b0;
         adc_ref_en_o        <= 1'b0;
         pin_digital_read_o  <= 1'b0;
      end else begin
         pin_ctrl_o.analog_route        <= pin_oe;
         pin_ctrl_o.digital_out_disable <= pin_oe;
         pin_ctrl_o.digital_in_disable  <= pin_oe;
         comparator_ref_en_o            <= 1'b1;
         adc_ref_en_o                   <= 1'b1;
         pin_digital_read_o             <= pin_oe ? 1'b0 : pin_digital_in_i;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_control_write;
      write_strobe && hit_control;
   endsequence

   a_enable_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(enable) |-> ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_LADDER)
      else $error("Ladder mode does not follow enable.");
   a_level_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      ladder_ctrl_o.ladder_level_code == $past(level))
      else $error("Level code not passed to ladder.");
   a_clamp_pos: assert property (@(posedge clk_i) disable iff (rst_i)
      (!enable && low_power && level == 5'h1F) |=>
      ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_CLAMP_POS && !ladder_ctrl_o.neg_connect)
      else $error("Positive clamp not applied.");
   a_clamp_neg: assert property (@(posedge clk_i) disable iff (rst_i)
      (!enable && !low_power && level == 5'h00) |=>
      ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_CLAMP_NEG && !ladder_ctrl_o.pos_connect)
      else $error("Negative clamp not applied.");
   a_pin_route: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_ctrl_o.analog_route == $past(pin_oe))
      else $error("Pin routing does not follow output enable.");
   a_pin_override: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_ctrl_o.analog_route |-> pin_ctrl_o.digital_out_disable && pin_ctrl_o.digital_in_disable)
      else $error("Digital pin paths not overridden.");
   a_pin_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(pin_oe) |-> !pin_digital_read_o)
      else $error("Routed pin reads nonzero.");
   a_neg_select: assert property (@(posedge clk_i) disable iff (rst_i)
      ladder_ctrl_o.neg_ext_pin == $past(control[0]))
      else $error("Negative source select mismatch.");
   a_reset_clear: assert property (@(posedge clk_i)
      rst_i |=> control == 8'h00 && level == 5'h00 && !pin_ctrl_o.analog_route)
      else $error("Reset did not clear converter state.");
   // The written byte is registered on the request edge, and the switches follow one edge later.
   a_write_latency: assert property (@(posedge clk_i) disable iff (rst_i)
      s_control_write |-> ##2
      (ladder_ctrl_o.neg_ext_pin == $past(dat_i[dac_ctrl_pkg::POS_NSS], 2) &&
       (ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_LADDER) ==
       $past(dat_i[dac_ctrl_pkg::POS_ENABLE], 2)))
      else $error("Switch controls lag the write.");

   // ----------------------------------------------------------------
   // Bus handshake assertions
   // ----------------------------------------------------------------
   sequence s_mapped_request;
      request && mapped;
   endsequence

   sequence s_unmapped_request;
      request && !mapped;
   endsequence

   sequence s_control_read;
      request && !we_i && hit_control;
   endsequence

   sequence s_level_read;
      request && !we_i && hit_level;
   endsequence

   // A held request must not be taken twice, so every answer lasts one cycle.
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("Acknowledge stands longer than one cycle.");

   a_err_single: assert property (@(posedge clk_i) disable iff (rst_i)
      err_o |=> !err_o)
      else $error("Error stands longer than one cycle.");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      s_mapped_request |=> ack_o && !err_o)
      else $error("Mapped request not acknowledged.");

   a_err_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      s_unmapped_request |=> err_o && !ack_o && dat_o == 32'h0000_0000)
      else $error("Unmapped request not refused.");

   // An unmapped write must leave both registers untouched.
   a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
      s_unmapped_request |=> $stable(control) && $stable(level))
      else $error("Unmapped write changed a register.");

   a_read_control: assert property (@(posedge clk_i) disable iff (rst_i)
      s_control_read |=> dat_o == {24'h00_0000, $past(control)})
      else $error("Control read data mismatch.");

   a_read_level: assert property (@(posedge clk_i) disable iff (rst_i)
      s_level_read |=> dat_o == {27'h000_0000, $past(level)})
      else $error("Level read data mismatch.");

   a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
      !ack_o |-> dat_o == 32'h0000_0000)
      else $error("Read data shown without acknowledge.");

   // ----------------------------------------------------------------
   // Ladder and pin assertions
   // ----------------------------------------------------------------
   a_ladder_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(enable) |-> ladder_ctrl_o.mode != dac_ctrl_pkg::MODE_LADDER)
      else $error("Ladder runs while disabled.");

   a_ladder_ends: assert property (@(posedge clk_i) disable iff (rst_i)
      ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_LADDER |->
      ladder_ctrl_o.pos_connect && ladder_ctrl_o.neg_connect)
      else $error("Running ladder has an open end.");

   // The off state must never close the negative end, or the ladder draws current.
   a_off_ends: assert property (@(posedge clk_i) disable iff (rst_i)
      ladder_ctrl_o.mode == dac_ctrl_pkg::MODE_OFF |-> !ladder_ctrl_o.neg_connect)
      else $error("Off state closes the negative end.");

   a_pos_select: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(control[dac_ctrl_pkg::POS_PSS_LO +: 2]) != 2'b11 |->
      ladder_ctrl_o.pos_source == $past(control[dac_ctrl_pkg::POS_PSS_LO +: 2]))
      else $error("Positive source select mismatch.");

   a_pos_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(control[dac_ctrl_pkg::POS_PSS_LO +: 2]) == 2'b11 |->
      ladder_ctrl_o.pos_source == dac_ctrl_pkg::POS_SRC_SUPPLY)
      else $error("Reserved positive select not parked on supply.");

   // The consumer enables come up one edge after reset ends.
   a_ref_consumers: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> comparator_ref_en_o && adc_ref_en_o)
      else $error("Reference not offered to comparator and ADC.");

   a_pin_disable_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !pin_ctrl_o.analog_route |->
      !pin_ctrl_o.digital_out_disable && !pin_ctrl_o.digital_in_disable)
      else $error("Digital pin paths overridden without routing.");

   // Outside the routed state the pad level passes with one cycle of delay.
   a_pin_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(pin_oe)) |-> pin_digital_read_o == $past(pin_digital_in_i))
      else $error("Pad level not passed to digital read.");

   a_reset_outputs: assert property (@(posedge clk_i)
      rst_i |=> ladder_ctrl_o == '0 && pin_ctrl_o == '0 && !ack_o && !err_o)
      else $error("Reset did not clear the outputs.");

endmodule
`default_nettype wire

// >>> dv/ratiometric_dac_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ratiometric_dac_control_tb;
   logic                          clk_i = 1'b0;
   logic                          rst_i = 1'b1;
   logic                          cyc_i = 1'b0;
   logic                          stb_i = 1'b0;
   logic                          we_i = 1'b0;
   logic [7:0]                    adr_i = 8'h00;
   logic [3:0]                    sel_i = 4'h0;
   logic [31:0]                   dat_i = 32'h0;
   logic                          pin_digital_in_i = 1'b1;
   logic [31:0]                   dat_o;
   logic                          ack_o;
   logic                          err_o;
   logic                          pin_digital_read_o;
   logic                          comparator_ref_en_o;
   logic                          adc_ref_en_o;
   dac_ctrl_pkg::ladder_ctrl_type ladder_ctrl_o;
   dac_ctrl_pkg::pin_ctrl_type    pin_ctrl_o;
   int                            errors = 0;
   int                            num_checks = 0;
   logic [31:0]                   rd;
   logic                          bad;
   localparam logic [7:0] CTL = dac_ctrl_pkg::ADDR_REFERENCE_CONTROL;
   localparam logic [7:0] LVL = dac_ctrl_pkg::ADDR_LEVEL_SELECT;

   always #2.5 clk_i = ~clk_i;

   ratiometric_dac_control ratiometric_dac_control_i (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .err_o(err_o), .pin_digital_in_i(pin_digital_in_i),
      .pin_digital_read_o(pin_digital_read_o), .ladder_ctrl_o(ladder_ctrl_o),
      .pin_ctrl_o(pin_ctrl_o), .comparator_ref_en_o(comparator_ref_en_o),
      .adc_ref_en_o(adc_ref_en_o));

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // The request is held until ack or err is sampled high, so a slow answer is tolerated.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= wr; adr_i <= a; dat_i <= d; sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      rd = dat_o;
      bad = err_o;
      chk("bus_answer", 32'h1, 32'(n < 20));
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hF);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(name, {24'h0, exp}, rd);
   endtask

   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #10000;
      errors++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("ref_en", 32'h3, {30'h0, comparator_ref_en_o, adc_ref_en_o});
      chk("mode_rst", 32'(dac_ctrl_pkg::MODE_CLAMP_NEG), 32'(ladder_ctrl_o.mode));
      chk("pin_rst", 32'h0, 32'(pin_ctrl_o));
      rdchk("ctl_rst", CTL, 8'h00);
      rdchk("lvl_rst", LVL, 8'h00);
      wr(CTL, 8'hFF);
      chk("mode_on", 32'h1, 32'(ladder_ctrl_o.mode));
      chk("pin_route", 32'h7, 32'(pin_ctrl_o));
      chk("pin_read", 32'h0, 32'(pin_digital_read_o));
      chk("pos_rsvd", 32'h0, 32'(ladder_ctrl_o.pos_source));
      rdchk("ctl_mask", CTL, 8'hED);
      wr(LVL, 8'hFF);
      rdchk("lvl_mask", LVL, 8'h1F);
      for (int i = 0; i < 32; i++) begin
         wr(LVL, 8'(i));
         chk("level", 32'(i), 32'(ladder_ctrl_o.ladder_level_code));
      end
      for (int i = 0; i < 3; i++) begin
         wr(CTL, 8'(8'h80 | (i << 2) | (i & 1)));
         chk("pos_src", 32'(i), 32'(ladder_ctrl_o.pos_source));
         chk("neg_src", 32'(i & 1), 32'(ladder_ctrl_o.neg_ext_pin));
         chk("pin_off", 32'h0, 32'(pin_ctrl_o));
         chk("pin_pad", 32'h1, 32'(pin_digital_read_o));
      end
      wr(CTL, 8'h44);
      wr(LVL, 8'h1F);
      chk("clamp_pos", 32'h2, 32'(ladder_ctrl_o.mode));
      wr(LVL, 8'h1E);
      chk("no_clamp", 32'h0, 32'(ladder_ctrl_o.mode));
      wr(CTL, 8'h01);
      wr(LVL, 8'h00);
      chk("clamp_neg", 32'h3, 32'(ladder_ctrl_o.mode));
      bus(1'b1, 8'h08, 32'hFF, 4'hF);
      chk("unmapped_err", 32'h1, 32'(bad));
      chk("unmapped_dat", 32'h0, rd);
      bus(1'b1, CTL, 32'hA0, 4'h0);
      rdchk("sel_off", CTL, 8'h01);
      wr(CTL, 8'hA0);
      wr(LVL, 8'h15);
      chk("code_pre", 32'h15, 32'(ladder_ctrl_o.ladder_level_code));
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("mode_rst2", 32'(dac_ctrl_pkg::MODE_CLAMP_NEG), 32'(ladder_ctrl_o.mode));
      chk("pin_rst2", 32'h0, 32'(pin_ctrl_o));
      chk("code_rst2", 32'h0, 32'(ladder_ctrl_o.ladder_level_code));
      rdchk("lvl_rst2", LVL, 8'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
